//--- src/dfsr_pkg.sv
// dfsr_pkg: register offsets, field positions, reset values and key codes
// for the data flash self-rewrite sequencer.
// assumes a 16-bit byte-addressed special function register bus.
package dfsr_pkg;

    // register byte addresses on the special function register bus
    localparam logic [15:0] OFF_PROG_ADDR_LOW = 16'hF0E0;
    localparam logic [15:0] OFF_PROG_ADDR_HIGH = 16'hF0E1;
    localparam logic [15:0] OFF_WRITE_DATA_LOW = 16'hF0E2;
    localparam logic [15:0] OFF_WRITE_DATA_HIGH = 16'hF0E3;
    localparam logic [15:0] OFF_ERASE_COMMAND = 16'hF0E4;
    localparam logic [15:0] OFF_UNLOCK_KEY = 16'hF0E5;
    localparam logic [15:0] OFF_SEGMENT_SELECT = 16'hF0E6;
    localparam logic [15:0] OFF_SELF_WRITE_ENABLE = 16'hF0E7;
    localparam logic [15:0] OFF_WRITE_PROTECT = 16'hF0E8;
    localparam logic [15:0] OFF_ERASE_STATE = 16'hF0EA;

    // every register comes out of reset as zero
    localparam logic [7:0] RST_BYTE = 8'h00;

    // field positions
    localparam int BLOCK_ERASE_START_BIT = 0;
    localparam int SECTOR_ERASE_START_BIT = 1;
    localparam int SELF_REWRITE_ON_BIT = 0;
    localparam int ERASING_BIT = 0;
    localparam int SECTOR_LSB = 1;
    localparam int SECTOR_MSB = 2;

    // address low bit 0 is tied to zero so word addresses stay even
    localparam logic [7:0] ADDR_LOW_MASK = 8'hFE;

    // only segment code 100b selects the data flash
    localparam logic [2:0] SEG_DATA_FLASH = 3'h4;

    // two-step unlock sequence
    localparam logic [7:0] KEY_FIRST = 8'hFA;
    localparam logic [7:0] KEY_SECOND = 8'hF5;

    // latched erase command encodings
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_BLOCK = 2'h1;
    localparam logic [1:0] CMD_SECTOR = 2'h2;

endpackage

//--- src/dfsr_unlock_if.sv
// dfsr_unlock_if: carries key writes and the unlock grant between the
// sequencer and its key acceptor.
// assumes both ends run on the same clock.
`timescale 1ns/100ps
interface dfsr_unlock_if;
    logic key_wr;
    logic [7:0] key_data;
    logic consume;
    logic unlocked;

    modport seq (output key_wr, output key_data, output consume, input unlocked);
    modport acc (input key_wr, input key_data, input consume, output unlocked);
endinterface

//--- src/dfsr_unlock.sv
// dfsr_unlock: two-step key acceptor granting one erase or word program.
// assumes key_wr is a one-cycle pulse from the register decode and that
// consume pulses in the cycle an operation is launched.
`timescale 1ns/100ps
module dfsr_unlock (
    input wire logic ref_clk,
    input wire logic rst_b,
    dfsr_unlock_if.acc unl
);
    import dfsr_pkg::*;

    typedef struct packed {
        logic armed;
        logic unlocked;
    } dfsr_unl_s;

    dfsr_unl_s st;
    dfsr_unl_s next_st;

    // first key arms, second key grants, any value other than the two keys disarms
    always_comb begin
        next_st = st;
        if (unl.consume) begin
            next_st.unlocked = 1'b0; // grant is one-shot
        end
        if (unl.key_wr) begin
            if (st.armed && unl.key_data == KEY_SECOND) begin
                next_st.unlocked = 1'b1;
                next_st.armed = 1'b0;
            end else if (unl.key_data == KEY_FIRST) begin
                next_st.armed = 1'b1;
            end else begin
                next_st.armed = 1'b0; // wrong value cancels the pending first key
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign unl.unlocked = st.unlocked;

endmodule

//--- src/dfsr_seq.sv
// dfsr_seq: data flash self-rewrite sequencer, registers and flash handshake.
// assumes a same-clock special function register bus with one-cycle
// read/write strobes and a flash array that pulses fl_done once per request.
//
// Contract
// - sector erase clears one 512-byte sector out of four.
// - block erase clears the whole 2 KB data flash at once.
// - programming writes exactly one 16-bit word per operation.
// - the processor keeps running while an erase is in progress.
// - each finished erase or program raises a completion interrupt pulse.
// - registers sit at F0E0h..F0E8h and F0EAh, all resetting to 00h.
// - address low bit 0 always reads zero and ignores writes.
// - address low gives program low address; address high gives upper address.
// - data bytes form the program word; writing the high byte starts programming.
// - the processor is halted while a word program runs.
// - interrupts are held pending during a word program; peripherals run.
// - control bit 0 starts block erase and clears itself on completion.
// - control bit 1 starts sector erase and clears itself on completion.
// - erase command 01 and 11 mean block, 10 sector, 00 nothing.
// - the erase control register is write-only and reads as zero.
// - address low and data low accept byte and 16-bit word access.
// - only the key pair FAh then F5h allows one operation.
// - the self-rewrite function works only while its enable bit is one.
// - protect bits stick until reset and block their sector and block erase.
`timescale 1ns/100ps
module dfsr_seq (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_word,
    input wire logic [15:0] sfr_wdata,
    output logic [15:0] sfr_rdata,
    input wire logic fl_done,
    output logic fl_erase_req,
    output logic fl_sector_sel,
    output logic fl_prog_req,
    output logic [15:0] fl_addr,
    output logic [15:0] fl_wdata,
    output logic cpu_stall,
    output logic irq_hold,
    output logic background_operation,
    output logic erase_program_done_irq
);
    import dfsr_pkg::*;

    typedef enum {DFSR_IDLE, DFSR_ERASE, DFSR_PROG} dfsr_state_e;

    typedef struct packed {
        dfsr_state_e state;
        logic [7:0] prog_addr_low;
        logic [7:0] prog_addr_high;
        logic [7:0] write_data_low;
        logic [7:0] write_data_high;
        logic [1:0] erase_command;
        logic [2:0] segment_select;
        logic self_rewrite_on;
        logic [3:0] write_protect;
        logic erasing;
        logic prog_busy;
        logic [15:0] rdata;
        logic erase_req;
        logic sector_sel;
        logic prog_req;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic done_irq;
    } dfsr_seq_s;

    dfsr_seq_s st;
    dfsr_seq_s next_st;
    dfsr_unlock_if unl ();

    logic word_ok;
    logic [7:0] hi_lane;
    logic wr_al;
    logic wr_ah;
    logic wr_dl;
    logic wr_dh;
    logic wr_cmd;
    logic wr_key;
    logic wr_seg;
    logic wr_slf;
    logic wr_prt;
    logic start_ok;
    logic [1:0] sec_idx;

    dfsr_unlock u_unlock (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .unl(unl)
    );

    // byte and word decode; a word access is honoured only at the two
    // even pair addresses, elsewhere it acts as a low-byte access
    assign word_ok = sfr_word && (sfr_addr == OFF_PROG_ADDR_LOW || sfr_addr == OFF_WRITE_DATA_LOW);
    assign hi_lane = word_ok ? sfr_wdata[15:8] : sfr_wdata[7:0];
    assign wr_al = sfr_wr && sfr_addr == OFF_PROG_ADDR_LOW;
    assign wr_ah = sfr_wr && (sfr_addr == OFF_PROG_ADDR_HIGH || (word_ok && sfr_addr == OFF_PROG_ADDR_LOW));
    assign wr_dl = sfr_wr && sfr_addr == OFF_WRITE_DATA_LOW;
    assign wr_dh = sfr_wr && (sfr_addr == OFF_WRITE_DATA_HIGH || (word_ok && sfr_addr == OFF_WRITE_DATA_LOW));
    assign wr_cmd = sfr_wr && sfr_addr == OFF_ERASE_COMMAND;
    assign wr_key = sfr_wr && sfr_addr == OFF_UNLOCK_KEY;
    assign wr_seg = sfr_wr && sfr_addr == OFF_SEGMENT_SELECT;
    assign wr_slf = sfr_wr && sfr_addr == OFF_SELF_WRITE_ENABLE;
    assign wr_prt = sfr_wr && sfr_addr == OFF_WRITE_PROTECT;

    // key writes go straight to the acceptor
    assign unl.key_wr = wr_key;
    assign unl.key_data = sfr_wdata[7:0];

    // a launch needs the grant, the enable, segment 4 and an idle engine
    assign start_ok = unl.unlocked && st.self_rewrite_on && st.segment_select == SEG_DATA_FLASH
        && st.state == DFSR_IDLE;
    assign sec_idx = st.prog_addr_high[SECTOR_MSB:SECTOR_LSB];
    assign unl.consume = st.erase_req || st.prog_req;

    // next-state logic: register writes, launches, completion, reads
    always_comb begin
        next_st = st;
        next_st.erase_req = 1'b0;
        next_st.prog_req = 1'b0;
        next_st.done_irq = 1'b0;
        if (wr_al) begin
            next_st.prog_addr_low = sfr_wdata[7:0] & ADDR_LOW_MASK;
        end
        if (wr_ah) begin
            next_st.prog_addr_high = hi_lane;
        end
        if (wr_dl) begin
            next_st.write_data_low = sfr_wdata[7:0];
        end
        if (wr_dh) begin
            next_st.write_data_high = hi_lane;
        end
        if (wr_seg) begin
            next_st.segment_select = sfr_wdata[2:0];
        end
        if (wr_slf) begin
            next_st.self_rewrite_on = sfr_wdata[SELF_REWRITE_ON_BIT];
        end
        if (wr_prt) begin
            next_st.write_protect = st.write_protect | sfr_wdata[3:0]; // ones stick until reset
        end
        // completion from the array ends whatever is running
        if (st.state != DFSR_IDLE && fl_done) begin
            next_st.state = DFSR_IDLE;
            next_st.erase_command = CMD_NONE; // self-clearing start bits
            next_st.erasing = 1'b0;
            next_st.prog_busy = 1'b0; // processor resumes
            next_st.done_irq = 1'b1;
        end
        // erase launch; bit 0 wins over bit 1 so 11 acts as block erase
        if (wr_cmd && (sfr_wdata[BLOCK_ERASE_START_BIT] || sfr_wdata[SECTOR_ERASE_START_BIT])) begin
            if (sfr_wdata[BLOCK_ERASE_START_BIT]) begin
                if (start_ok && st.write_protect == 4'h0) begin // any lock blocks block erase
                    next_st.state = DFSR_ERASE;
                    next_st.erase_command = CMD_BLOCK;
                    next_st.erasing = 1'b1; // cpu is not stalled
                    next_st.erase_req = 1'b1;
                    next_st.sector_sel = 1'b0;
                    next_st.addr = {st.prog_addr_high, 8'h00};
                end
            end else if (start_ok && !st.write_protect[sec_idx]) begin
                next_st.state = DFSR_ERASE;
                next_st.erase_command = CMD_SECTOR;
                next_st.erasing = 1'b1;
                next_st.erase_req = 1'b1;
                next_st.sector_sel = 1'b1;
                next_st.addr = {st.prog_addr_high, 8'h00};
            end
        end
        // word program launch on a high data byte write
        if (wr_dh && start_ok && !st.write_protect[sec_idx]) begin
            next_st.state = DFSR_PROG;
            next_st.prog_busy = 1'b1; // halts cpu and holds interrupts
            next_st.prog_req = 1'b1;
            next_st.addr = {st.prog_addr_high, st.prog_addr_low};
            next_st.wdata = {hi_lane, wr_dl ? sfr_wdata[7:0] : st.write_data_low};
        end
        // read mux; write-only registers and holes read zero
        if (sfr_rd) begin
            unique case (sfr_addr)
                OFF_PROG_ADDR_LOW: next_st.rdata = {word_ok ? st.prog_addr_high : 8'h00, st.prog_addr_low};
                OFF_PROG_ADDR_HIGH: next_st.rdata = {8'h00, st.prog_addr_high};
                OFF_WRITE_DATA_LOW: next_st.rdata = {word_ok ? st.write_data_high : 8'h00, st.write_data_low};
                OFF_WRITE_DATA_HIGH: next_st.rdata = {8'h00, st.write_data_high};
                OFF_SEGMENT_SELECT: next_st.rdata = {13'h0000, st.segment_select};
                OFF_SELF_WRITE_ENABLE: next_st.rdata = {15'h0000, st.self_rewrite_on};
                OFF_WRITE_PROTECT: next_st.rdata = {12'h000, st.write_protect};
                OFF_ERASE_STATE: next_st.rdata = {15'h0000, st.erasing};
                default: next_st.rdata = 16'h0000; // command and key are write-only
            endcase
        end
    end

    // all state in one register; every field resets to zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{state: DFSR_IDLE, prog_addr_low: RST_BYTE, prog_addr_high: RST_BYTE,
                    write_data_low: RST_BYTE, write_data_high: RST_BYTE, erase_command: CMD_NONE,
                    segment_select: 3'h0, self_rewrite_on: 1'b0, write_protect: 4'h0,
                    erasing: 1'b0, prog_busy: 1'b0, rdata: 16'h0000, erase_req: 1'b0,
                    sector_sel: 1'b0, prog_req: 1'b0, addr: 16'h0000, wdata: 16'h0000,
                    done_irq: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign sfr_rdata = st.rdata;
    assign fl_erase_req = st.erase_req;
    assign fl_sector_sel = st.sector_sel;
    assign fl_prog_req = st.prog_req;
    assign fl_addr = st.addr;
    assign fl_wdata = st.wdata;
    assign cpu_stall = st.prog_busy;
    assign irq_hold = st.prog_busy; // peripherals keep running, only servicing waits
    assign background_operation = st.erasing;
    assign erase_program_done_irq = st.done_irq;

    // checks on the sequencer's own outputs and state register fields
    property p_addr_low_even;
        @(posedge ref_clk) disable iff (!rst_b)
        sfr_rd && sfr_addr == OFF_PROG_ADDR_LOW |=> sfr_rdata[0] == 1'b0;
    endproperty
    a_addr_low_even: assert property (p_addr_low_even) else $error("address low bit 0 read as one");

    property p_cmd_reads_zero;
        @(posedge ref_clk) disable iff (!rst_b)
        sfr_rd && (sfr_addr == OFF_ERASE_COMMAND || sfr_addr == OFF_UNLOCK_KEY) |=> sfr_rdata == 16'h0000;
    endproperty
    a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("write-only register read nonzero");

    property p_prog_stalls;
        @(posedge ref_clk) disable iff (!rst_b)
        fl_prog_req |-> cpu_stall && irq_hold && !background_operation;
    endproperty
    a_prog_stalls: assert property (p_prog_stalls) else $error("program launched without stall");

    property p_erase_no_stall;
        @(posedge ref_clk) disable iff (!rst_b)
        background_operation |-> !cpu_stall;
    endproperty
    a_erase_no_stall: assert property (p_erase_no_stall) else $error("cpu stalled during erase");

    property p_done_pulse;
        @(posedge ref_clk) disable iff (!rst_b)
        st.state != DFSR_IDLE && fl_done |=> erase_program_done_irq && !cpu_stall && !background_operation;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("completion did not raise interrupt");

    property p_protect_sticky;
        @(posedge ref_clk) disable iff (!rst_b)
        ##1 (st.write_protect & $past(st.write_protect)) == $past(st.write_protect);
    endproperty
    a_protect_sticky: assert property (p_protect_sticky) else $error("protect bit cleared");

    property p_block_needs_no_lock;
        @(posedge ref_clk) disable iff (!rst_b)
        fl_erase_req && !fl_sector_sel |-> $past(st.write_protect) == 4'h0;
    endproperty
    a_block_needs_no_lock: assert property (p_block_needs_no_lock) else $error("block erase while locked");

    property p_busy_ignores;
        @(posedge ref_clk) disable iff (!rst_b)
        st.state != DFSR_IDLE |=> !fl_erase_req && !fl_prog_req;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("launch while busy");

    property p_launch_guarded;
        @(posedge ref_clk) disable iff (!rst_b)
        fl_erase_req || fl_prog_req |-> $past(unl.unlocked) && $past(st.self_rewrite_on)
            && $past(st.segment_select) == SEG_DATA_FLASH ##1 !unl.unlocked;
    endproperty
    a_launch_guarded: assert property (p_launch_guarded) else $error("launch without unlock or enable");

    property p_prog_word;
        @(posedge ref_clk) disable iff (!rst_b)
        fl_prog_req |-> fl_wdata == {st.write_data_high, st.write_data_low} && fl_addr[0] == 1'b0;
    endproperty
    a_prog_word: assert property (p_prog_word) else $error("program word mismatch");

    property p_cmd_autoclear;
        @(posedge ref_clk) disable iff (!rst_b)
        st.erase_command != CMD_NONE && fl_done |=> st.erase_command == CMD_NONE;
    endproperty
    a_cmd_autoclear: assert property (p_cmd_autoclear) else $error("erase bit did not clear");

    property p_erase_addr;
        @(posedge ref_clk) disable iff (!rst_b)
        fl_erase_req |-> fl_addr == {$past(st.prog_addr_high), 8'h00};
    endproperty
    a_erase_addr: assert property (p_erase_addr) else $error("erase address wrong");

    property p_prog_addr;
        @(posedge ref_clk) disable iff (!rst_b)
        fl_prog_req |-> fl_addr == {$past(st.prog_addr_high), $past(st.prog_addr_low)};
    endproperty
    a_prog_addr: assert property (p_prog_addr) else $error("program address wrong");

    property p_self_off;
        @(posedge ref_clk) disable iff (!rst_b)
        !st.self_rewrite_on |=> !fl_erase_req && !fl_prog_req;
    endproperty
    a_self_off: assert property (p_self_off) else $error("launch with self-rewrite off");

    property p_bad_segment;
        @(posedge ref_clk) disable iff (!rst_b)
        st.segment_select != SEG_DATA_FLASH |=> !fl_erase_req && !fl_prog_req;
    endproperty
    a_bad_segment: assert property (p_bad_segment) else $error("launch with invalid segment");

    property p_lock_blocks;
        @(posedge ref_clk) disable iff (!rst_b)
        fl_prog_req || (fl_erase_req && fl_sector_sel) |-> ($past(st.write_protect) & (4'h1 << $past(sec_idx))) == 4'h0;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("locked sector touched");

    property p_status_read;
        @(posedge ref_clk) disable iff (!rst_b)
        sfr_rd && sfr_addr == OFF_ERASE_STATE |=> sfr_rdata == {15'h0000, $past(background_operation)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_sector_kind;
        @(posedge ref_clk) disable iff (!rst_b)
        fl_erase_req |-> fl_sector_sel == (st.erase_command == CMD_SECTOR);
    endproperty
    a_sector_kind: assert property (p_sector_kind) else $error("erase kind mismatch");

    // main scenarios
    c_block_erase: cover property (@(posedge ref_clk) disable iff (!rst_b) fl_erase_req && !fl_sector_sel);
    c_sector_erase: cover property (@(posedge ref_clk) disable iff (!rst_b) fl_erase_req && fl_sector_sel);
    c_word_prog: cover property (@(posedge ref_clk) disable iff (!rst_b) fl_prog_req);
    c_done: cover property (@(posedge ref_clk) disable iff (!rst_b) erase_program_done_irq);
    c_busy_start: cover property (@(posedge ref_clk) disable iff (!rst_b) background_operation && wr_dh);

endmodule

//--- tb/dfsr_flash_model.sv
// dfsr_flash_model: behavioural flash array answering erase and program requests.
// assumes one-cycle request pulses on ref_clk and at most one request at a time.
`timescale 1ns/100ps
module dfsr_flash_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic erase_req,
    input wire logic prog_req,
    input wire logic slow,
    output logic done
);
    int cnt;

    // one done pulse per request; slow mode keeps the array busy long enough to poke it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            done <= 1'b0;
        end else begin
            done <= (cnt == 1);
            if (erase_req || prog_req) begin
                cnt <= slow ? 40 : 3;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

//--- tb/dfsr_seq_bench.sv
// dfsr_seq_bench: register-level tests of the data flash sequencer.
// assumes the flash array model in dfsr_flash_model and a 20 MHz clock.
`timescale 1ns/100ps
module dfsr_seq_bench;
    import dfsr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b, sfr_wr, sfr_rd, sfr_word, fl_done, slow;
    logic [15:0] sfr_addr, sfr_wdata, sfr_rdata, fl_addr, fl_wdata, cap_addr, cap_data;
    logic fl_erase_req, fl_sector_sel, fl_prog_req, cpu_stall, irq_hold, bg, irq;
    logic cap_sel, cap_stall, cap_hold, cap_bg, done_d;
    int miscompares, n_tests, n_erase, n_prog, n_irq, cycles;
    logic [15:0] offs [11] = '{OFF_PROG_ADDR_LOW, OFF_PROG_ADDR_HIGH, OFF_WRITE_DATA_LOW, OFF_WRITE_DATA_HIGH,
        OFF_ERASE_COMMAND, OFF_UNLOCK_KEY, OFF_SEGMENT_SELECT, OFF_SELF_WRITE_ENABLE, OFF_WRITE_PROTECT,
        OFF_ERASE_STATE, 16'hF0E9};

    always #25 ref_clk = ~ref_clk;

    dfsr_seq i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_word(sfr_word), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .fl_done(fl_done),
        .fl_erase_req(fl_erase_req), .fl_sector_sel(fl_sector_sel), .fl_prog_req(fl_prog_req),
        .fl_addr(fl_addr), .fl_wdata(fl_wdata), .cpu_stall(cpu_stall), .irq_hold(irq_hold),
        .background_operation(bg), .erase_program_done_irq(irq));

    dfsr_flash_model i_flash (.ref_clk(ref_clk), .rst_b(rst_b), .erase_req(fl_erase_req),
        .prog_req(fl_prog_req), .slow(slow), .done(fl_done));

    task automatic test_done();
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // monitor at the falling edge, where registered outputs have settled
    always @(negedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
        if (fl_erase_req === 1'b1 || fl_prog_req === 1'b1) begin
            n_erase += int'(fl_erase_req);
            n_prog += int'(fl_prog_req);
            cap_addr = fl_addr;
            cap_data = fl_wdata;
            cap_sel = fl_sector_sel;
            cap_stall = cpu_stall;
            cap_hold = irq_hold;
            cap_bg = bg;
        end
        if (irq === 1'b1 || done_d === 1'b1) begin
            chk("done_irq", 16'(irq), 16'(done_d));
        end
        n_irq += int'(irq === 1'b1);
        done_d = fl_done;
    end

    // one write strobe; a spare cycle follows so strobes never collide
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_word = w;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask

    // read data lands one cycle after the sampling edge; byte reads compare [7:0]
    task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] exp);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_word = w;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        @(negedge ref_clk);
        chk("rdata", w ? sfr_rdata : {8'h00, sfr_rdata[7:0]}, exp);
    endtask

    task automatic unlock();
        wr(OFF_UNLOCK_KEY, 16'h00FA, 1'b0);
        wr(OFF_UNLOCK_KEY, 16'h00F5, 1'b0);
    endtask

    task automatic wait_irq(input int ci);
        for (int i = 0; i < 60 && n_irq == ci; i++) begin
            @(negedge ref_clk);
        end
    endtask

    // issue a start write and count the erases, programs and completions it caused
    task automatic launch(input logic [15:0] a, input logic [15:0] d, input logic w, input int ee, input int ep);
        int ce;
        int cp;
        int ci;
        ce = n_erase;
        cp = n_prog;
        ci = n_irq;
        wr(a, d, w);
        wait_irq(ci);
        repeat (3) @(negedge ref_clk);
        chk("erase_req", 16'(n_erase - ce), 16'(ee));
        chk("prog_req", 16'(n_prog - cp), 16'(ep));
        chk("irq_count", 16'(n_irq - ci), 16'(ee + ep));
    endtask

    initial begin
        sfr_addr = 16'h0000;
        sfr_wdata = 16'h0000;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_word = 1'b0;
        slow = 1'b0;
        rst_b = 1'b0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_b = 1'b1;
        foreach (offs[i]) rd(offs[i], 1'b0, 16'h0000);
        wr(OFF_PROG_ADDR_LOW, 16'h00FF, 1'b0);
        rd(OFF_PROG_ADDR_LOW, 1'b0, 16'h00FE);
        wr(OFF_PROG_ADDR_LOW, 16'h0235, 1'b1);
        rd(OFF_PROG_ADDR_LOW, 1'b1, 16'h0234);
        // self-rewrite still off: a granted start must do nothing
        wr(OFF_SEGMENT_SELECT, 16'h0004, 1'b0);
        unlock();
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 0, 0);
        rd(OFF_ERASE_COMMAND, 1'b0, 16'h0000);
        rd(OFF_UNLOCK_KEY, 1'b0, 16'h0000);
        wr(OFF_SELF_WRITE_ENABLE, 16'h0001, 1'b0);
        rd(OFF_SELF_WRITE_ENABLE, 1'b0, 16'h0001);
        wr(OFF_SEGMENT_SELECT, 16'h0005, 1'b0);
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 0, 0);
        // kept grant now serves a sector erase of the second sector
        wr(OFF_SEGMENT_SELECT, 16'h0004, 1'b0);
        wr(OFF_PROG_ADDR_HIGH, 16'h0002, 1'b0);
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 1, 0);
        chk("erase_addr", cap_addr, 16'h0200);
        chk("sector_sel", 16'(cap_sel), 16'h0001);
        chk("bg_during", 16'(cap_bg), 16'h0001);
        chk("stall_erase", 16'(cap_stall), 16'h0000);
        rd(OFF_ERASE_STATE, 1'b0, 16'h0000);
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 0, 0);
        wr(OFF_UNLOCK_KEY, 16'h00FA, 1'b0);
        wr(OFF_UNLOCK_KEY, 16'h0000, 1'b0);
        wr(OFF_UNLOCK_KEY, 16'h00F5, 1'b0);
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 0, 0);
        // command codes 00, 01 and 11 with a block address
        wr(OFF_PROG_ADDR_HIGH, 16'h0000, 1'b0);
        unlock();
        launch(OFF_ERASE_COMMAND, 16'h0000, 1'b0, 0, 0);
        for (int c = 1; c < 4; c += 2) begin
            unlock();
            launch(OFF_ERASE_COMMAND, 16'(c), 1'b0, 1, 0);
            chk("block_sel", 16'(cap_sel), 16'h0000);
            chk("block_addr", cap_addr, 16'h0000);
        end
        // word program by bytes, low data byte first
        wr(OFF_PROG_ADDR_LOW, 16'h0134, 1'b1);
        wr(OFF_WRITE_DATA_LOW, 16'h005A, 1'b0);
        unlock();
        launch(OFF_WRITE_DATA_HIGH, 16'h00A5, 1'b0, 0, 1);
        chk("prog_addr", cap_addr, 16'h0134);
        chk("prog_data", cap_data, 16'hA55A);
        chk("stall", 16'(cap_stall), 16'h0001);
        chk("irq_hold", 16'(cap_hold), 16'h0001);
        chk("stall_end", 16'(cpu_stall), 16'h0000);
        unlock();
        launch(OFF_WRITE_DATA_LOW, 16'hBEEF, 1'b1, 0, 1);
        chk("word_data", cap_data, 16'hBEEF);
        // a program start while a long erase runs is ignored and the grant survives
        slow = 1'b1;
        wr(OFF_PROG_ADDR_HIGH, 16'h0004, 1'b0);
        unlock();
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 1, 0);
        unlock();
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 1, 0);
        unlock();
        wr(OFF_ERASE_COMMAND, 16'h0002, 1'b0);
        unlock();
        wr(OFF_WRITE_DATA_HIGH, 16'h0011, 1'b0);
        rd(OFF_ERASE_STATE, 1'b0, 16'h0001);
        chk("busy_prog", 16'(n_prog), 16'h0002);
        chk("busy_erase", 16'(n_erase), 16'h0006);
        chk("busy_irq", 16'(n_irq), 16'h0007);
        wait_irq(n_irq);
        launch(OFF_WRITE_DATA_HIGH, 16'h0022, 1'b0, 0, 1);
        slow = 1'b0;
        // protect bits stick and block their sector, programs there and block erase
        wr(OFF_WRITE_PROTECT, 16'h0002, 1'b0);
        wr(OFF_WRITE_PROTECT, 16'h0000, 1'b0);
        rd(OFF_WRITE_PROTECT, 1'b0, 16'h0002);
        wr(OFF_PROG_ADDR_HIGH, 16'h0002, 1'b0);
        unlock();
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 0, 0);
        launch(OFF_WRITE_DATA_HIGH, 16'h0033, 1'b0, 0, 0);
        wr(OFF_PROG_ADDR_HIGH, 16'h0000, 1'b0);
        launch(OFF_ERASE_COMMAND, 16'h0001, 1'b0, 0, 0);
        wr(OFF_PROG_ADDR_HIGH, 16'h0006, 1'b0);
        launch(OFF_ERASE_COMMAND, 16'h0002, 1'b0, 1, 0);
        chk("free_sector", cap_addr, 16'h0600);
        test_done();
    end
endmodule
